/* design/frews_pkg.sv */
/*
 * Shared constants and types of the Flash row erase / write sequencer:
 * register offsets, control field positions, reset values and timing.
 * Assumes a 125 MHz system clock and a 32-bit APB register port.
 */
package frews_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses on APB)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_ADDR_LOW = 8'h00;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFF_DATA_LOW = 8'h08;
    localparam logic [7:0] OFF_DATA_HIGH = 8'h0c;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_UNLOCK = 8'h14;

    // ------------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------------
    localparam int CTL_READ = 0;
    localparam int CTL_WRITE = 1;
    localparam int CTL_WRITE_ENABLE = 2;
    localparam int CTL_ERROR = 3;
    localparam int CTL_ERASE_SELECT = 4;
    localparam int CTL_LATCH_ONLY = 5;
    localparam int CTL_CONFIG_SELECT = 6;

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'haa;
    localparam logic [13:0] LATCH_BLANK = 14'h3fff;
    localparam int LATCH_COUNT = 32;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SETUP_CYCLES = 2;
    localparam logic [1:0] SETUP_LAST = 2'(SETUP_CYCLES - 1);
    localparam int STALL_TIME_NS = 2000000;
    localparam int STALL_CYCLES_DEF = STALL_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_BUSY} frews_phase_t;
    typedef enum logic [1:0] {UNL_NONE, UNL_FIRST, UNL_ARMED} frews_unlock_t;

    typedef struct packed {
        frews_phase_t phase;
        frews_unlock_t unlock;
        logic [1:0] setup_cnt;
        logic [31:0] timer;
        logic [7:0] flash_addr_low;
        logic [6:0] flash_addr_high;
        logic [7:0] flash_data_low;
        logic [5:0] flash_data_high;
        logic config_space_select;
        logic latch_only;
        logic erase_select;
        logic program_error_flag;
        logic write_enable;
        logic write_ctrl;
        logic op_erase;
        logic op_program;
        logic [31:0][13:0] latch;
    } frews_state_t;

endpackage

/* design/frews_top.sv */
/*
 * Flash row erase / write sequencer: APB register file, unlock checker,
 * 32-word write latch bank, forced setup cycles and self-timed core stall.
 * Assumes the core reaches the registers over APB on SYS_CLK, and that the
 * Flash array takes a row address plus erase or program levels and the
 * whole latch bank in parallel while those levels stand.
 */
`timescale 1ns/1ns

module frews_top #(
    parameter int unsigned STALL_CYCLES = frews_pkg::STALL_CYCLES_DEF
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic CORE_FORCE_NOP,
    output logic CORE_STALL,
    output logic [9:0] FLASH_ROW,
    output logic FLASH_ERASE,
    output logic FLASH_PROGRAM,
    output logic [447:0] FLASH_ROW_DATA
);

    // ------------------------------------------------------------------
    // Reset value of the whole state
    // ------------------------------------------------------------------
    localparam frews_pkg::frews_state_t ST_RESET = '{
        phase: frews_pkg::PH_IDLE,
        unlock: frews_pkg::UNL_NONE,
        setup_cnt: 2'h0,
        timer: 32'h0,
        flash_addr_low: 8'h00,
        flash_addr_high: 7'h00,
        flash_data_low: 8'h00,
        flash_data_high: 6'h00,
        config_space_select: 1'b0,
        latch_only: 1'b0,
        erase_select: 1'b0,
        program_error_flag: 1'b0,
        write_enable: 1'b0,
        write_ctrl: 1'b0,
        op_erase: 1'b0,
        op_program: 1'b0,
        latch: {frews_pkg::LATCH_COUNT{frews_pkg::LATCH_BLANK}}
    };

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Next unlock step for a byte written to the unlock register
    function automatic frews_pkg::frews_unlock_t unlock_step(
        input frews_pkg::frews_unlock_t cur,
        input logic [7:0] val
    );
        frews_pkg::frews_unlock_t res;
        res = frews_pkg::UNL_NONE;
        case (val)
            frews_pkg::UNLOCK_FIRST: begin
                // A fresh 55h always restarts the sequence
                res = frews_pkg::UNL_FIRST;
            end
            frews_pkg::UNLOCK_SECOND: begin
                if (cur == frews_pkg::UNL_FIRST) begin
                    res = frews_pkg::UNL_ARMED;
                end
            end
            default: begin
                res = frews_pkg::UNL_NONE;
            end
        endcase
        return res;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        logic res;
        case (a)
            frews_pkg::OFF_ADDR_LOW, frews_pkg::OFF_ADDR_HIGH: begin
                res = 1'b1;
            end
            frews_pkg::OFF_DATA_LOW, frews_pkg::OFF_DATA_HIGH: begin
                res = 1'b1;
            end
            frews_pkg::OFF_CONTROL, frews_pkg::OFF_UNLOCK: begin
                res = 1'b1;
            end
            default: begin
                res = 1'b0;
            end
        endcase
        return res;
    endfunction

    // Every latch at the erased value
    function automatic logic [31:0][13:0] blank_bank();
        logic [31:0][13:0] res;
        for (int i = 0; i < frews_pkg::LATCH_COUNT; i++) begin
            res[i] = frews_pkg::LATCH_BLANK;
        end
        return res;
    endfunction

    // Latch word from the two data registers
    function automatic logic [13:0] word_of(input logic [5:0] hi, input logic [7:0] lo);
        return {hi, lo};
    endfunction

    // Row number: upper ten bits of the fifteen-bit word address
    function automatic logic [9:0] row_of(input logic [6:0] hi, input logic [7:0] lo);
        return {hi, lo[7:5]};
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    frews_pkg::frews_state_t st;
    frews_pkg::frews_state_t next_st;
    logic idle;
    logic access;
    logic wr_access;
    logic start_ok;
    logic wr_control;
    logic start_req;

    // Loaded one short: the cycle in which the timer reads zero still stalls
    localparam logic [31:0] STALL_LOAD = 32'(STALL_CYCLES - 1);

    // The core bus is held off while an operation runs; that is how the
    // core halts. Nothing is clock-gated, so the rest of the chip runs on.
    assign idle = st.phase == frews_pkg::PH_IDLE;
    assign access = PSEL & PENABLE & idle & CE;
    assign wr_access = access & PWRITE;

    // Start needs the armed unlock, write enable and program space.
    assign start_ok = st.unlock == frews_pkg::UNL_ARMED
        && PWDATA[frews_pkg::CTL_WRITE_ENABLE]
        && !PWDATA[frews_pkg::CTL_CONFIG_SELECT];

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------
    assign wr_control = wr_access && PADDR == frews_pkg::OFF_CONTROL;
    // A write of 0 to the write bit is no start attempt at all.
    assign start_req = wr_control && PWDATA[frews_pkg::CTL_WRITE];

    always_comb begin
        next_st = st;
        // CE low freezes every field; PREADY drops too, so no transfer is lost
        if (CE) begin
            case (st.phase)
                frews_pkg::PH_IDLE: begin
                    if (wr_access) begin
                        // Any register write other than to the unlock or control register
                        // breaks a pending unlock.
                        if (PADDR != frews_pkg::OFF_UNLOCK && PADDR != frews_pkg::OFF_CONTROL) begin
                            next_st.unlock = frews_pkg::UNL_NONE;
                        end
                        case (PADDR)
                            frews_pkg::OFF_ADDR_LOW: begin
                                next_st.flash_addr_low = PWDATA[7:0];
                            end
                            frews_pkg::OFF_ADDR_HIGH: begin
                                next_st.flash_addr_high = PWDATA[6:0];
                            end
                            frews_pkg::OFF_DATA_LOW: begin
                                next_st.flash_data_low = PWDATA[7:0];
                            end
                            frews_pkg::OFF_DATA_HIGH: begin
                                next_st.flash_data_high = PWDATA[5:0];
                            end
                            frews_pkg::OFF_UNLOCK: begin
                                next_st.unlock = unlock_step(st.unlock, PWDATA[7:0]);
                            end
                            frews_pkg::OFF_CONTROL: begin
                                next_st.config_space_select = PWDATA[frews_pkg::CTL_CONFIG_SELECT];
                                next_st.latch_only = PWDATA[frews_pkg::CTL_LATCH_ONLY];
                                next_st.erase_select = PWDATA[frews_pkg::CTL_ERASE_SELECT];
                                next_st.program_error_flag = PWDATA[frews_pkg::CTL_ERROR];
                                next_st.write_enable = PWDATA[frews_pkg::CTL_WRITE_ENABLE];
                                // Writing 0 to the write bit is ignored.
                                // Every set attempt consumes the unlock.
                                if (start_req) begin
                                    next_st.unlock = frews_pkg::UNL_NONE;
                                    // Flag raised on each attempt; the set wins
                                    // over a software clear in the same write.
                                    next_st.program_error_flag = 1'b1;
                                    if (start_ok) begin
                                        next_st.write_ctrl = 1'b1;
                                        next_st.phase = frews_pkg::PH_SETUP;
                                        next_st.setup_cnt = 2'h0;
                                        if (PWDATA[frews_pkg::CTL_ERASE_SELECT]) begin
                                            next_st.op_erase = 1'b1;
                                        end else begin
                                            // Address low bits pick the latch.
                                            next_st.latch[st.flash_addr_low[4:0]] =
                                                word_of(st.flash_data_high, st.flash_data_low);
                                            next_st.op_program = !PWDATA[frews_pkg::CTL_LATCH_ONLY];
                                        end
                                    end
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                frews_pkg::PH_SETUP: begin
                    // Two forced no-op cycles before anything else.
                    if (st.setup_cnt == frews_pkg::SETUP_LAST) begin
                        if (st.op_erase || st.op_program) begin
                            next_st.phase = frews_pkg::PH_BUSY;
                            next_st.timer = STALL_LOAD;
                        end else begin
                            // Latch-only load ends here without a stall.
                            // Latches keep their contents for the next load
                            next_st.phase = frews_pkg::PH_IDLE;
                            next_st.write_ctrl = 1'b0;
                            next_st.program_error_flag = 1'b0;
                        end
                    end else begin
                        next_st.setup_cnt = 2'(st.setup_cnt + 2'h1);
                    end
                end
                frews_pkg::PH_BUSY: begin
                    // Latches and row stay frozen so the array sees one image
                    if (st.timer == 32'h0) begin
                        // Core released in the next cycle, when PREADY rises.
                        next_st.phase = frews_pkg::PH_IDLE;
                        next_st.write_ctrl = 1'b0;
                        next_st.erase_select = 1'b0;
                        next_st.program_error_flag = 1'b0;
                        next_st.op_erase = 1'b0;
                        next_st.op_program = 1'b0;
                        next_st.latch = blank_bank();
                    end else begin
                        next_st.timer = 32'(st.timer - 32'h1);
                    end
                end
                default: begin
                    next_st.phase = frews_pkg::PH_IDLE;
                end
            endcase
        end
    end

    // Write enable and all control bits clear at reset.
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------
    // Zero wait states while idle; a transfer during an operation waits
    // until the operation ends, which is what holds the core.
    assign PREADY = idle & CE;
    // Unmapped addresses answer at once with an error; a write there only breaks a pending unlock
    assign PSLVERR = access & !is_mapped(PADDR);

    always_comb begin
        PRDATA = 32'h0;
        if (access && !PWRITE) begin
            case (PADDR)
                frews_pkg::OFF_ADDR_LOW: begin
                    PRDATA = {24'h0, st.flash_addr_low};
                end
                frews_pkg::OFF_ADDR_HIGH: begin
                    PRDATA = {24'h0, 1'b1, st.flash_addr_high};
                end
                frews_pkg::OFF_DATA_LOW: begin
                    PRDATA = {24'h0, st.flash_data_low};
                end
                frews_pkg::OFF_DATA_HIGH: begin
                    PRDATA = {26'h0, st.flash_data_high};
                end
                frews_pkg::OFF_CONTROL: begin
                    // Top bit reads 1, read bit reads 0
                    PRDATA = {24'h0, 1'b1,
                        st.config_space_select,
                        st.latch_only,
                        st.erase_select,
                        st.program_error_flag,
                        st.write_enable,
                        st.write_ctrl,
                        1'b0};
                end
                default: begin
                    // Unlock register is write only and reads 0
                    PRDATA = 32'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Core and array side
    // ------------------------------------------------------------------
    assign CORE_FORCE_NOP = st.phase == frews_pkg::PH_SETUP;
    assign CORE_STALL = st.phase == frews_pkg::PH_BUSY;
    // The row is the upper ten address bits only; low bits never reach
    // the array, so a commit cannot cross a row.
    assign FLASH_ROW = row_of(st.flash_addr_high, st.flash_addr_low);
    // Erase and program are separate levels: a program never erases.
    assign FLASH_ERASE = CORE_STALL & st.op_erase;
    // Whole bank, blank words included, goes to the row.
    assign FLASH_PROGRAM = CORE_STALL & st.op_program;
    // Latch bank drives the array directly; no copy is taken at the start
    assign FLASH_ROW_DATA = st.latch;

endmodule

/* verif/flash_row_erase_write_sequencer_tb.sv */
/* Self-checking bench: the core model drives APB, a latch model built from
   integers and a queue predicts every result. Assumes a shortened stall. */
`timescale 1ns/1ns
module flash_row_erase_write_sequencer_tb;
    localparam int STALL = 6;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, force_nop, stall, f_erase, f_prog, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [9:0] f_row, row;
    logic [447:0] row_data;
    logic [7:0] bad_ctl[5] = '{8'h12, 8'h56, 8'h16, 8'h16, 8'h16};
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int lat[32];
    int loaded_q[$];
    frews_top #(.STALL_CYCLES(STALL)) dut (.SYS_CLK(sys_clk), .RESETN(resetn), .CE(ce),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CORE_FORCE_NOP(force_nop),
        .CORE_STALL(stall), .FLASH_ROW(f_row), .FLASH_ERASE(f_erase), .FLASH_PROGRAM(f_prog),
        .FLASH_ROW_DATA(row_data));
    frews_core_model u_core (.clk(sys_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[FAIL] %0t run did not finish in time", $time);
            give_verdict();
        end
    end
    task automatic cmp(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic [447:0] bank();
        logic [447:0] b;
        foreach (lat[i]) b[14*i +: 14] = 14'(lat[i]);
        return b;
    endfunction
    // Loads one word, unlocks in mode um, starts with ctl and watches the busy window
    task automatic load(input int idx, input logic [7:0] ctl, input int busy, input int um,
            input bit prog);
        logic [13:0] w;
        int n;
        int n_er;
        int n_pr;
        logic [447:0] cap;
        logic [9:0] cap_row;
        w = 14'($urandom);
        n = 0;
        n_er = 0;
        n_pr = 0;
        u_core.wr(frews_pkg::OFF_ADDR_LOW, {24'h0, row[2:0], 5'(idx)});
        u_core.wr(frews_pkg::OFF_DATA_LOW, {24'h0, w[7:0]});
        u_core.wr(frews_pkg::OFF_DATA_HIGH, {26'h0, w[13:8]});
        if (busy > 0) lat[idx] = w;
        if (busy > 0) loaded_q.push_back(idx);
        u_core.unlock(um);
        u_core.wr(frews_pkg::OFF_CONTROL, {24'h0, ctl});
        repeat (STALL + 8) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
            n++;
            n_er += int'(f_erase === 1'b1);
            n_pr += int'(f_prog === 1'b1);
            if (stall === 1'b1) cap = row_data;
            if (stall === 1'b1) cap_row = f_row;
        end
        cmp(n == busy, "busy window length");
        cmp(n_er == ((busy > 2 && !prog) ? STALL : 0), "erase level");
        cmp(n_pr == ((busy > 2 && prog) ? STALL : 0), "program level");
        if (busy > 2) cmp(cap_row === row, "row address");
        if (prog) cmp(cap === bank(), "programmed row data");
        if (busy > 2) foreach (lat[i]) lat[i] = frews_pkg::LATCH_BLANK;
        if (busy > 2) loaded_q.delete();
        cmp(row_data === bank(), "latch bank");
    endtask
    initial begin
        void'($urandom(32'h3357));
        foreach (lat[i]) lat[i] = frews_pkg::LATCH_BLANK;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        u_core.rd(frews_pkg::OFF_CONTROL, d, e);
        cmp(d[7:0] === 8'h80, "control after reset");
        cmp(row_data === bank(), "latches after reset");
        u_core.rd(8'h18, d, e);
        cmp(e === 1'b1 && d === 32'h0, "unmapped read");
        for (int r = 0; r < 3; r++) begin
            u_core.gap = r;
            if (r < 2) row = 10'($urandom);
            u_core.wr(frews_pkg::OFF_ADDR_HIGH, {25'h0, row[9:3]});
            // Third pass rewrites the second row: erase, reload, program
            if (r != 1) load($urandom_range(31), 8'h16, 2 + STALL, 0, 0);
            if (r > 0) begin
                load(0, 8'h26, 2, 0, 0);
                repeat ($urandom_range(30)) load($urandom_range(31), 8'h26, 2, 0, 0);
                load(31, 8'h06, 2 + STALL, 0, 1);
            end
            u_core.rd(frews_pkg::OFF_CONTROL, d, e);
            cmp(d[7:0] === 8'h84, "control after operation");
        end
        for (int c = 0; c < 5; c++) begin
            load(c, bad_ctl[c], 0, (c < 2) ? 0 : c - 1, 0);
            u_core.rd(frews_pkg::OFF_CONTROL, d, e);
            cmp(d[3] === 1'b1 && d[1] === 1'b0, "refused start");
        end
        ce <= 1'b0;
        repeat (4) @(posedge sys_clk);
        cmp(pready === 1'b0 && stall === 1'b0, "clock enable low holds the bus");
        ce <= 1'b1;
        give_verdict();
    end
endmodule

/* verif/frews_core_model.sv */
/* Behavioural processor core acting as APB master of the sequencer.
   Assumes pready, prdata and pslverr come straight from the sequencer. */
`timescale 1ns/1ns
module frews_core_model (
    input wire logic clk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    int gap = 0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Holding the access while pready is low is how the core sits out no-ops and stall
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rdat, output logic err);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~wd;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, wd, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
        xfer(1'b0, a, 32'h0, r, e);
    endtask
    // Mode 0 is the proper sequence; modes 1 to 3 break it for refusal tests
    task automatic unlock(input int um);
        if (um == 3) wr(frews_pkg::OFF_UNLOCK, {24'h0, frews_pkg::UNLOCK_SECOND});
        wr(frews_pkg::OFF_UNLOCK, {24'h0, frews_pkg::UNLOCK_FIRST});
        if (um == 1) wr(frews_pkg::OFF_UNLOCK, 32'h0);
        if (um != 3) wr(frews_pkg::OFF_UNLOCK, {24'h0, frews_pkg::UNLOCK_SECOND});
        if (um == 2) wr(frews_pkg::OFF_DATA_LOW, 32'h0);
    endtask
endmodule

/* verif/frews_top_chk.sv */
/* Concurrent checks on the ports of the Flash row sequencer top.
   Assumes one clock, SYS_CLK, and RESETN asynchronous active low. */
`timescale 1ns/1ns
module frews_chk #(
    parameter int unsigned STALL_CYCLES = 4
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic CORE_FORCE_NOP,
    input wire logic CORE_STALL,
    input wire logic [9:0] FLASH_ROW,
    input wire logic FLASH_ERASE,
    input wire logic FLASH_PROGRAM,
    input wire logic [447:0] FLASH_ROW_DATA
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    int unsigned stall_cnt;
    logic ctl_wr;
    assign ctl_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == frews_pkg::OFF_CONTROL;
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            stall_cnt <= 0;
        end else begin
            stall_cnt <= CORE_STALL ? stall_cnt + 1 : 0;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    nop_two_a: assert property ($rose(CORE_FORCE_NOP) |-> CORE_FORCE_NOP[*2] ##1 !CORE_FORCE_NOP)
        else $error("forced no-op window is not two cycles");
    stall_after_nop_a: assert property ($rose(CORE_STALL) |-> $past(CORE_FORCE_NOP))
        else $error("stall began without the no-op window");
    stall_len_a: assert property ($fell(CORE_STALL) |-> stall_cnt == STALL_CYCLES)
        else $error("stall length differs from the timed interval");
    busy_ready_a: assert property ((CORE_STALL || CORE_FORCE_NOP) |-> !PREADY)
        else $error("core released while an operation runs");
    level_in_stall_a: assert property ((FLASH_ERASE || FLASH_PROGRAM) |-> CORE_STALL
        && !(FLASH_ERASE && FLASH_PROGRAM)) else $error("array level outside stall");
    latch_blank_a: assert property ($fell(CORE_STALL) |-> FLASH_ROW_DATA == {32{14'h3fff}})
        else $error("latches not blank after operation");
    row_hold_a: assert property (CORE_STALL && $past(CORE_STALL) |->
        $stable(FLASH_ROW) && $stable(FLASH_ROW_DATA)) else $error("row moved during commit");
    no_write_enable_start_a: assert property (ctl_wr && !PWDATA[2] |=> !CORE_FORCE_NOP)
        else $error("start accepted with write enable clear");
    unmapped_err_a: assert property (PSEL && PENABLE && PADDR > 8'h14 |-> PSLVERR && PRDATA == 0)
        else $error("unmapped access not flagged");
endmodule

bind frews_top frews_chk #(.STALL_CYCLES(STALL_CYCLES)) u_chk (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CORE_FORCE_NOP(CORE_FORCE_NOP), .CORE_STALL(CORE_STALL), .FLASH_ROW(FLASH_ROW),
    .FLASH_ERASE(FLASH_ERASE), .FLASH_PROGRAM(FLASH_PROGRAM), .FLASH_ROW_DATA(FLASH_ROW_DATA));
